/* File: fgc_pkg.sv */
/*
 Shared constants and carrier types for the fieldbus gateway command decoder.
 Assumes frames arrive already delimited and checked by an upstream framer.
*/
`default_nettype none
package fgc_pkg;
   // Function codes
   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_INPUTS = 8'h02;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INREG = 8'h04;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_REG = 8'h06;
   localparam logic [7:0] FC_EXC_STAT = 8'h07;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WR_COILS = 8'h0F;
   localparam logic [7:0] FC_WR_REGS = 8'h10;
   localparam logic [7:0] FC_DG_RECV = 8'h44;
   localparam logic [7:0] FC_DG_SEND = 8'h48;
   // Diagnostic sub-functions
   localparam logic [15:0] SF_ECHO = 16'h0000;
   localparam logic [15:0] SF_RESTART = 16'h0001;
   localparam logic [15:0] SF_DIAGREG = 16'h0002;
   localparam logic [15:0] SF_DELIM = 16'h0003;
   localparam logic [15:0] SF_LISTEN = 16'h0004;
   localparam logic [15:0] SF_CLEAR = 16'h000A;
   localparam logic [15:0] SF_BUS_MSG = 16'h000B;
   localparam logic [15:0] SF_NO_RESP = 16'h000F;
   // Quantity limits and address span
   localparam logic [15:0] MAX_BITS = 16'h07D0;
   localparam logic [15:0] MAX_WORDS = 16'h007D;
   localparam logic [16:0] ADDR_SPAN = 17'h10000;
   // Exception codes
   localparam logic [7:0] EX_ILL_FUNC = 8'h01;
   localparam logic [7:0] EX_ILL_ADDR = 8'h02;
   localparam logic [7:0] EX_ILL_VAL = 8'h03;
   localparam logic [7:0] EX_DEV_FAIL = 8'h04;
   localparam logic [7:0] EX_NONE = 8'h00;
   // Addresses and defaults
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] OWN_RST = 8'h01;
   localparam logic [7:0] DELIM_RST = 8'h0A;
   localparam logic [15:0] REF_NONE_LO = 16'h0000;
   localparam logic [15:0] REF_NONE_HI = 16'hFFFF;
   localparam int REF_TYPE_BIT = 15;
   // Counter slots
   localparam int CNT_BUS = 0;
   localparam int CNT_CRC = 1;
   localparam int CNT_EXC = 2;
   localparam int CNT_SLAVE = 3;
   localparam int CNT_NORSP = 4;
   localparam int NCNT = 5;
   // Register offsets
   localparam logic [7:0] R_OWN = 8'h00;
   localparam logic [7:0] R_STAT = 8'h04;
   localparam logic [7:0] R_DIAG = 8'h08;
   localparam logic [7:0] R_CNT_BASE = 8'h0C;
   localparam logic [7:0] R_SEL = 8'h20;
   localparam logic [7:0] R_REF = 8'h24;
   localparam logic [7:0] R_CFG = 8'h28;

   typedef enum logic {ST_IDLE, ST_EXEC} fgc_state_e;
   typedef enum logic {RK_NORMAL, RK_EXCEPT} fgc_kind_e;

   typedef struct packed {
      logic crc_err;
      logic [7:0] slave;
      logic [7:0] func;
      logic [15:0] start; // Start address, or sub-function for diagnostics
      logic [15:0] qty;
      logic [15:0] data;
   } fgc_cmd_s;

   typedef struct packed {
      fgc_kind_e kind;
      logic [7:0] func;
      logic [7:0] exc;
      logic [15:0] data;
   } fgc_rsp_s;

   typedef struct packed {
      logic valid;
      logic word_type;
      logic input_space;
      logic [14:0] addr;
   } fgc_map_s;
endpackage : fgc_pkg
`default_nettype wire

/* File: fgc_decoder.sv */
/*
 Command decoder of the serial slave: executes function codes, diagnostics,
 datagram exchange and field-bus reference mapping.
 Assumes an upstream framer delivers one checked frame per CMD_VALID pulse and
 a downstream data store carries out the accesses announced on EXEC.
*/
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Accept codes 1-8,15,16; bit counts up to 2000, word counts up to 125
// - Diagnostic 00 echoes the two query data bytes unchanged
// - Diagnostic 01 restarts communications and sends no response
// - Diagnostic 02 returns the 16-bit diagnostics register
// - Diagnostic 03 replaces the ASCII delimiter; line feed after reset
// - Diagnostic 04 enters listen-only and sends no response
// - Diagnostic 10 zeroes all counters and the diagnostics register
// - Diagnostics 11-15 return the five communication counters
// - Function 68 fetches a field-bus datagram, 72 sends one
// - Lower 15 reference bits give the device's starting address
// - Reference top bit selects bit space or word space
// - Reference 0 or FFFF leaves the device unmapped
// - Device point configuration picks input or output space
// - On error nothing executes; exception codes 01 to 04 may answer
// - Broadcast runs only broadcast-capable functions and never answers
// - Act on own address (1-247) and answer it, except in listen-only and for diagnostics 01 and 04
module fgc_decoder
   import fgc_pkg::*;
#(
   parameter int NDEV = 32,
   parameter int PTW = 10
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // Register port
   input wire logic [7:0] BUS_ADDR,
   input wire logic [31:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   output logic [31:0] BUS_RDATA,
   // Command in
   input wire logic CMD_VALID,
   input wire fgc_cmd_s CMD,
   output logic CMD_READY,
   // Response out
   output logic RSP_VALID,
   output fgc_rsp_s RSP,
   // Data access out
   output logic EXEC_VALID,
   output fgc_cmd_s EXEC,
   // Device status and datagram side
   input wire logic [7:0] EXC_STATUS,
   input wire logic DG_RX_AVAIL,
   input wire logic DG_TX_BUSY,
   output logic DG_RX_REQ,
   output logic DG_TX_REQ,
   output logic COMM_RESTART,
   output logic LISTEN_ONLY,
   output logic [7:0] DELIM,
   // Reference map lookup
   input wire logic [$clog2(NDEV)-1:0] MAP_DEV,
   input wire logic [PTW-1:0] MAP_POINT,
   output fgc_map_s MAP
);
   localparam int DW = $clog2(NDEV);

   typedef struct packed {
      fgc_state_e st;
      fgc_cmd_s cmd;
      logic [7:0] own;
      logic listen;
      logic [7:0] delim;
      logic [15:0] diag;
      logic [NCNT-1:0][15:0] cnt;
      logic [DW-1:0] sel;
      logic [NDEV-1:0][15:0] refa;
      logic [NDEV-1:0][PTW-1:0] in_pts;
      logic rsp_v;
      fgc_rsp_s rsp;
      logic exec_v;
      logic dg_rx;
      logic dg_tx;
      logic restart;
      fgc_map_s map;
      logic [31:0] rdata;
   } fgc_st_s;

   fgc_st_s q, d;
   fgc_cmd_s c;
   logic mine, bcast, bc_ok, silent, run, answer;
   logic w_clear, w_delim, w_listen, w_restart, w_rx, w_tx, w_exec;
   logic [7:0] exc;
   logic [15:0] rdat, r;

   assign c = q.cmd;

   // Next state: bus access, command execution, map lookup
   always_comb begin
      d = q;
      d.rsp_v = 1'b0;
      d.exec_v = 1'b0;
      d.dg_rx = 1'b0;
      d.dg_tx = 1'b0;
      d.restart = 1'b0;
      mine = c.slave == q.own;
      bcast = c.slave == ADDR_BCAST;
      bc_ok = 1'b0;
      silent = 1'b0;
      exc = EX_NONE;
      rdat = 16'h0000;
      w_clear = 1'b0;
      w_delim = 1'b0;
      w_listen = 1'b0;
      w_restart = 1'b0;
      w_rx = 1'b0;
      w_tx = 1'b0;
      w_exec = 1'b0;
      run = 1'b0;
      answer = 1'b0;

      // Register writes; a table entry is reached through the select register
      if (BUS_WR) begin
         unique case (BUS_ADDR)
            R_OWN: d.own = BUS_WDATA[7:0];
            R_DIAG: d.diag = BUS_WDATA[15:0];
            R_SEL: d.sel = BUS_WDATA[DW-1:0];
            R_REF: d.refa[q.sel] = BUS_WDATA[15:0];
            R_CFG: d.in_pts[q.sel] = BUS_WDATA[PTW-1:0];
            default: ;
         endcase
      end
      // Read data stand only in the cycle after the strobe
      d.rdata = 32'h0000_0000;
      if (BUS_RD) begin
         unique case (BUS_ADDR)
            R_OWN: d.rdata = {24'h00_0000, q.own};
            R_STAT: d.rdata = {23'h00_0000, q.listen, q.delim};
            R_DIAG: d.rdata = {16'h0000, q.diag};
            R_SEL: d.rdata = 32'(q.sel);
            R_REF: d.rdata = {16'h0000, q.refa[q.sel]};
            R_CFG: d.rdata = 32'(q.in_pts[q.sel]);
            default: begin
               for (int i = 0; i < NCNT; i++) begin
                  if (BUS_ADDR == R_CNT_BASE + 8'(4 * i)) d.rdata = {16'h0000, q.cnt[i]};
               end
            end
         endcase
      end

      unique case (q.st)
         ST_IDLE: begin
            if (CMD_VALID) begin
               d.cmd = CMD;
               d.st = ST_EXEC;
            end
         end
         ST_EXEC: begin
            d.st = ST_IDLE;
            // Decode first, commit afterwards, so a refused command changes only the counters
            unique case (c.func)
               FC_RD_COILS, FC_RD_INPUTS, FC_WR_COILS: begin
                  bc_ok = c.func == FC_WR_COILS;
                  if (c.qty == 16'h0000 || c.qty > MAX_BITS) exc = EX_ILL_VAL;
                  else if (17'(c.start) + 17'(c.qty) > ADDR_SPAN) exc = EX_ILL_ADDR;
                  w_exec = 1'b1;
               end
               FC_RD_HOLD, FC_RD_INREG, FC_WR_REGS: begin
                  bc_ok = c.func == FC_WR_REGS;
                  if (c.qty == 16'h0000 || c.qty > MAX_WORDS) exc = EX_ILL_VAL;
                  else if (17'(c.start) + 17'(c.qty) > ADDR_SPAN) exc = EX_ILL_ADDR;
                  w_exec = 1'b1;
               end
               FC_WR_COIL, FC_WR_REG: begin
                  bc_ok = 1'b1;
                  w_exec = 1'b1;
                  rdat = c.data;
               end
               FC_EXC_STAT: rdat = {8'h00, EXC_STATUS};
               FC_DIAG: begin
                  rdat = c.data;
                  if (c.start == SF_ECHO) begin
                     rdat = c.data;
                  end else if (c.start == SF_RESTART) begin
                     bc_ok = 1'b1;
                     silent = 1'b1;
                     w_restart = 1'b1;
                  end else if (c.start == SF_DIAGREG) begin
                     rdat = q.diag;
                  end else if (c.start == SF_DELIM) begin
                     bc_ok = 1'b1;
                     w_delim = 1'b1;
                  end else if (c.start == SF_LISTEN) begin
                     bc_ok = 1'b1;
                     silent = 1'b1;
                     w_listen = 1'b1;
                  end else if (c.start == SF_CLEAR) begin
                     bc_ok = 1'b1;
                     w_clear = 1'b1;
                  end else if (c.start >= SF_BUS_MSG && c.start <= SF_NO_RESP) begin
                     rdat = q.cnt[3'(c.start - SF_BUS_MSG)];
                  end else begin
                     exc = EX_ILL_VAL;
                  end
               end
               FC_DG_RECV: begin
                  if (!DG_RX_AVAIL) exc = EX_DEV_FAIL;
                  w_rx = 1'b1;
               end
               FC_DG_SEND: begin
                  bc_ok = 1'b1;
                  if (DG_TX_BUSY) exc = EX_DEV_FAIL;
                  w_tx = 1'b1;
               end
               default: exc = EX_ILL_FUNC;
            endcase

            d.cnt[CNT_BUS] = q.cnt[CNT_BUS] + 16'h0001;
            if (c.crc_err) begin
               d.cnt[CNT_CRC] = q.cnt[CNT_CRC] + 16'h0001;
            end else if (mine || bcast) begin
               d.cnt[CNT_SLAVE] = q.cnt[CNT_SLAVE] + 16'h0001;
               // Only a restart gets through listen-only; broadcast needs capability
               run = (exc == EX_NONE) && (w_restart || (!q.listen && (mine || bc_ok)));
               answer = mine && !q.listen && !silent;
               if (answer) begin
                  d.rsp_v = 1'b1;
                  d.rsp.func = c.func;
                  d.rsp.data = rdat;
                  d.rsp.exc = exc;
                  d.rsp.kind = (exc == EX_NONE) ? RK_NORMAL : RK_EXCEPT;
                  if (exc != EX_NONE) d.cnt[CNT_EXC] = q.cnt[CNT_EXC] + 16'h0001;
               end else begin
                  d.cnt[CNT_NORSP] = q.cnt[CNT_NORSP] + 16'h0001;
               end
               if (run) begin
                  d.exec_v = w_exec;
                  d.dg_rx = w_rx;
                  d.dg_tx = w_tx;
                  if (w_restart) begin
                     d.restart = 1'b1;
                     d.listen = 1'b0;
                  end
                  if (w_listen) d.listen = 1'b1;
                  if (w_delim) d.delim = c.data[15:8];
                  // Clearing also drops the count of the clearing command itself
                  if (w_clear) begin
                     d.cnt = '0;
                     d.diag = 16'h0000;
                  end
               end
            end
         end
      endcase

      // Reference lookup; configuring tools keep references within 1 to FFFE
      r = q.refa[MAP_DEV];
      d.map.valid = !(r == REF_NONE_LO || r == REF_NONE_HI);
      d.map.word_type = r[REF_TYPE_BIT];
      d.map.addr = r[14:0] + 15'(MAP_POINT);
      d.map.input_space = MAP_POINT < q.in_pts[MAP_DEV];
   end

   // State register
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '0;
         q.own <= OWN_RST;
         q.delim <= DELIM_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign CMD_READY = q.st == ST_IDLE;
   assign BUS_RDATA = q.rdata;
   assign RSP_VALID = q.rsp_v;
   assign RSP = q.rsp;
   assign EXEC_VALID = q.exec_v;
   assign EXEC = q.cmd;
   assign DG_RX_REQ = q.dg_rx;
   assign DG_TX_REQ = q.dg_tx;
   assign COMM_RESTART = q.restart;
   assign LISTEN_ONLY = q.listen;
   assign DELIM = q.delim;
   assign MAP = q.map;

   // Checks; a taken command answers two edges later
   logic acc, own_ok;
   assign acc = CMD_VALID && CMD_READY && !CMD.crc_err;
   assign own_ok = acc && CMD.slave == q.own && !q.listen;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);

   AST_BIT_LIMIT: assert property (
      own_ok && CMD.func == FC_RD_COILS && CMD.qty > MAX_BITS
      |-> ##2 RSP_VALID && RSP.kind == RK_EXCEPT && RSP.exc == EX_ILL_VAL)
      else $error("bit quantity limit not refused");
   AST_ECHO: assert property (
      own_ok && CMD.func == FC_DIAG && CMD.start == SF_ECHO
      |-> ##2 RSP_VALID && RSP.data == $past(CMD.data, 2))
      else $error("echo data altered");
   AST_RESTART: assert property (
      acc && CMD.slave == q.own && CMD.func == FC_DIAG && CMD.start == SF_RESTART
      |-> ##2 COMM_RESTART && !RSP_VALID && !LISTEN_ONLY)
      else $error("restart misbehaved");
   AST_DIAGREG: assert property (
      own_ok && CMD.func == FC_DIAG && CMD.start == SF_DIAGREG && !BUS_WR
      |-> ##2 RSP_VALID && RSP.data == $past(q.diag, 1))
      else $error("diagnostics register not returned");
   AST_DELIM: assert property (
      own_ok && CMD.func == FC_DIAG && CMD.start == SF_DELIM
      |-> ##2 DELIM == $past(CMD.data[15:8], 2))
      else $error("delimiter not replaced");
   AST_LISTEN: assert property (
      own_ok && CMD.func == FC_DIAG && CMD.start == SF_LISTEN
      |-> ##2 LISTEN_ONLY && !RSP_VALID)
      else $error("listen-only not entered");
   AST_CLEAR: assert property (
      own_ok && CMD.func == FC_DIAG && CMD.start == SF_CLEAR && !BUS_WR
      |-> ##2 q.cnt == '0 && q.diag == 16'h0000)
      else $error("counters not cleared");
   AST_UNMAPPED: assert property (
      q.refa[MAP_DEV] == REF_NONE_LO || q.refa[MAP_DEV] == REF_NONE_HI |=> !MAP.valid)
      else $error("unmapped device shows as mapped");
   AST_BCAST_QUIET: assert property (
      CMD_VALID && CMD_READY && CMD.slave == ADDR_BCAST |-> ##2 !RSP_VALID)
      else $error("broadcast answered");
   AST_SILENT: assert property (
      CMD_VALID && CMD_READY && q.listen |-> ##2 !RSP_VALID)
      else $error("answered while listen-only");

   COV_READ: cover property (own_ok && CMD.func == FC_RD_HOLD ##2 RSP_VALID);
   COV_EXCEPT: cover property (RSP_VALID && RSP.kind == RK_EXCEPT);
   COV_LISTEN_EXIT: cover property (LISTEN_ONLY ##1 COMM_RESTART);
   COV_BCAST_WRITE: cover property (EXEC_VALID && EXEC.slave == ADDR_BCAST);
endmodule : fgc_decoder
`default_nettype wire

/* File: fgc_master_model.sv */
/*
 Serial master model: offers one command frame at a time and collects the answer.
 Assumes send is entered in the time step of a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module fgc_master_model
   import fgc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Command side
   input wire logic cmd_ready,
   output var logic cmd_valid,
   output var fgc_cmd_s cmd,
   // Response side
   input wire logic rsp_valid,
   input wire fgc_rsp_s rsp
);
   logic got;
   logic timed_out;
   fgc_rsp_s last;

   // Idle lines after time zero
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
      timed_out = 1'b0;
   end

   // Hold the frame until the edge that takes it, then scramble the released lines
   // so a decoder that samples late sees garbage rather than a lucky copy
   task automatic send(input fgc_cmd_s c);
      int n;
      n = 0;
      cmd_valid <= 1'b1;
      cmd <= c;
      do begin
         @(posedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 20);
      timed_out = (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      cmd <= ~c;
      // The answer pulse stands in the second cycle after the taking edge
      @(posedge clk);
      @(posedge clk);
      got = rsp_valid;
      last = rsp;
   endtask : send
endmodule : fgc_master_model
`default_nettype wire

/* File: fgc_decoder_test.sv */
/*
 Self-checking bench of the command decoder: a table of ordinary frames, then
 hand-written checks. Assumes the master model of fgc_master_model.sv.
*/
`timescale 1ns/10ps
`default_nettype none
module fgc_decoder_test
   import fgc_pkg::*;
;
   typedef struct packed {
      fgc_cmd_s c;
      logic [7:0] ec;
      logic xv;
      logic cd;
   } fgc_row_s;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] exc_status = 8'h5A;
   logic dg_rx_avail = 1'b0;
   logic dg_tx_busy = 1'b0;
   logic [4:0] map_dev = 5'h00;
   logic [9:0] map_point = 10'h000;
   logic [31:0] bus_rdata, rd;
   logic cmd_valid, cmd_ready, rsp_valid, exec_valid, got, xv, rxq, txq, rsq;
   logic dg_rx_req, dg_tx_req, comm_restart, listen_only;
   logic [7:0] delim;
   fgc_cmd_s cmd, exec, tc;
   fgc_rsp_s rsp, rs;
   fgc_map_s map;
   fgc_row_s rows [14];
   int fails = 0;
   int comparisons = 0;
   int cnt_exp [5] = '{3, 1, 1, 2, 0};

   always #20 core_clk = ~core_clk;

   fgc_decoder u_fgc_decoder (
      .CORE_CLK(core_clk), .NRST(nrst), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
      .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .CMD_VALID(cmd_valid),
      .CMD(cmd), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP(rsp),
      .EXEC_VALID(exec_valid), .EXEC(exec), .EXC_STATUS(exc_status),
      .DG_RX_AVAIL(dg_rx_avail), .DG_TX_BUSY(dg_tx_busy), .DG_RX_REQ(dg_rx_req),
      .DG_TX_REQ(dg_tx_req), .COMM_RESTART(comm_restart), .LISTEN_ONLY(listen_only),
      .DELIM(delim), .MAP_DEV(map_dev), .MAP_POINT(map_point), .MAP(map));

   fgc_master_model u_fgc_master_model (
      .clk(core_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd),
      .rsp_valid(rsp_valid), .rsp(rsp));

   // Count one comparison, report a miss at once
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (!ok) begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   // Single place where the run ends
   task automatic close_out();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // Register write; waits an edge first so a strobe is never re-raised in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask : wr

   // Register read; data stand only in the cycle after the strobe
   task automatic rdr(input logic [7:0] a);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      @(posedge core_clk);
      rd = bus_rdata;
   endtask : rdr

   function automatic fgc_cmd_s mk(logic [7:0] f, logic [15:0] s, logic [15:0] q,
      logic [15:0] d);
      mk = '{1'b0, OWN_RST, f, s, q, d};
   endfunction : mk

   function automatic fgc_row_s r(logic [7:0] f, logic [15:0] s, logic [15:0] q,
      logic [15:0] d, logic [7:0] ec, logic x, logic cd);
      r = '{mk(f, s, q, d), ec, x, cd};
   endfunction : r

   // One command through the master; side pulses sampled in the answer cycle
   task automatic cmd_go(input fgc_cmd_s c);
      u_fgc_master_model.send(c);
      got = u_fgc_master_model.got;
      rs = u_fgc_master_model.last;
      xv = exec_valid;
      rxq = dg_rx_req;
      txq = dg_tx_req;
      rsq = comm_restart;
      if (u_fgc_master_model.timed_out !== 1'b0) begin
         fails++;
         $display("[ERR] %0t command never taken", $time);
         close_out();
      end
   endtask : cmd_go

   task automatic ans(input logic [7:0] ec, input logic cd, input logic [15:0] d);
      chk(got === 1'b1 && rs.kind === (ec == EX_NONE ? RK_NORMAL : RK_EXCEPT), "kind");
      chk(rs.exc === ec, "exception code");
      chk(!cd || rs.data === d, "response data");
   endtask : ans

   task automatic lk(input logic [4:0] dv, input logic [9:0] pt, input fgc_map_s e);
      map_dev <= dv;
      map_point <= pt;
      @(posedge core_clk);
      @(posedge core_clk);
      chk(e.valid ? map === e : map.valid === 1'b0, "map lookup");
   endtask : lk

   // Hang guard
   initial begin
      repeat (30000) @(posedge core_clk);
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
   end

   initial begin
      rows[0] = r(FC_RD_COILS, 16'h0000, MAX_BITS, 16'h0000, EX_NONE, 1'b1, 1'b0);
      rows[1] = r(FC_RD_COILS, 16'h0000, 16'h07D1, 16'h0000, EX_ILL_VAL, 1'b0, 1'b0);
      rows[2] = r(FC_RD_INPUTS, 16'h0000, 16'h0000, 16'h0000, EX_ILL_VAL, 1'b0, 1'b0);
      rows[3] = r(FC_RD_INPUTS, 16'h0010, 16'h0001, 16'h0000, EX_NONE, 1'b1, 1'b0);
      rows[4] = r(FC_RD_HOLD, 16'h0000, MAX_WORDS, 16'h0000, EX_NONE, 1'b1, 1'b0);
      rows[5] = r(FC_RD_INREG, 16'h0000, 16'h007E, 16'h0000, EX_ILL_VAL, 1'b0, 1'b0);
      rows[6] = r(FC_WR_COIL, 16'h0005, 16'h0001, 16'hFF00, EX_NONE, 1'b1, 1'b1);
      rows[7] = r(FC_WR_REG, 16'h0006, 16'h0001, 16'h1234, EX_NONE, 1'b1, 1'b1);
      rows[8] = r(FC_WR_COILS, 16'hF830, MAX_BITS, 16'h0000, EX_NONE, 1'b1, 1'b0);
      rows[9] = r(FC_WR_REGS, 16'hFF84, MAX_WORDS, 16'h0000, EX_ILL_ADDR, 1'b0, 1'b0);
      rows[10] = r(8'h09, 16'h0000, 16'h0001, 16'h0000, EX_ILL_FUNC, 1'b0, 1'b0);
      // Data field carries the status byte that the bench ties to the input
      rows[11] = r(FC_EXC_STAT, 16'h0000, 16'h0008, 16'h005A, EX_NONE, 1'b0, 1'b1);
      rows[12] = r(FC_DIAG, SF_ECHO, 16'h0000, 16'hA55A, EX_NONE, 1'b0, 1'b1);
      rows[13] = r(FC_DIAG, 16'h0005, 16'h0000, 16'h0000, EX_ILL_VAL, 1'b0, 1'b0);
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      foreach (rows[i]) begin
         cmd_go(rows[i].c);
         ans(rows[i].ec, rows[i].cd, rows[i].c.data);
         chk(xv === rows[i].xv, "data access pulse");
         chk(rs.func === rows[i].c.func && exec === rows[i].c, "echoed command");
      end
      $display("table done");
      // Reset values and the register port
      chk(delim === DELIM_RST && listen_only === 1'b0, "reset state");
      rdr(R_OWN);
      chk(rd === 32'h1, "own address");
      wr(R_STAT, 32'hFFFF);
      rdr(R_STAT);
      chk(rd === 32'h0A, "status read-only");
      rdr(8'hFC);
      chk(rd === 32'h0, "unmapped read");
      $display("reset test done");
      // Diagnostics register, clearing and counters
      wr(R_DIAG, 32'hBEEF);
      cmd_go(mk(FC_DIAG, SF_DIAGREG, 16'h0000, 16'h0000));
      ans(EX_NONE, 1'b1, 16'hBEEF);
      cmd_go(mk(FC_DIAG, SF_CLEAR, 16'h0000, 16'h0000));
      rdr(R_DIAG);
      chk(rd === 32'h0, "diag cleared");
      tc = mk(FC_RD_HOLD, 16'h0000, 16'h0001, 16'h0000);
      tc.crc_err = 1'b1;
      cmd_go(tc);
      chk(got === 1'b0, "answer to bad frame");
      cmd_go(mk(FC_RD_HOLD, 16'h0000, 16'h0001, 16'h0000));
      cmd_go(mk(8'h09, 16'h0000, 16'h0001, 16'h0000));
      for (int k = 0; k < NCNT; k++) begin
         rdr(R_CNT_BASE + 8'(4 * k));
         chk(rd === 32'(cnt_exp[k]), "counter value");
      end
      // The first query is itself an addressed message, so the slave count moves on
      for (int k = 1; k < NCNT; k += 2) begin
         cmd_go(mk(FC_DIAG, SF_BUS_MSG + 16'(k), 16'h0000, 16'h0000));
         ans(EX_NONE, 1'b1, 16'(cnt_exp[k] + int'(k == 3)));
      end
      $display("counter test done");
      cmd_go(mk(FC_DIAG, SF_DELIM, 16'h0000, 16'h3A00));
      rdr(R_STAT);
      chk(delim === 8'h3A && rd === 32'h3A, "delimiter");
      // Listen-only keeps counting but stays silent until a restart
      cmd_go(mk(FC_DIAG, SF_LISTEN, 16'h0000, 16'h0000));
      chk(got === 1'b0 && listen_only === 1'b1, "enter listen");
      rdr(R_CNT_BASE + 8'h0C);
      tc.data = rd[15:0] + 16'h1;
      cmd_go(mk(FC_RD_HOLD, 16'h0000, 16'h0001, 16'h0000));
      chk(got === 1'b0 && xv === 1'b0, "silent in listen");
      rdr(R_CNT_BASE + 8'h0C);
      chk(rd[15:0] === tc.data, "counting in listen");
      cmd_go(mk(FC_DIAG, SF_RESTART, 16'h0000, 16'h0000));
      chk(got === 1'b0 && rsq === 1'b1 && listen_only === 1'b0, "restart");
      $display("listen test done");
      // Broadcast and foreign addresses
      tc = mk(FC_WR_REG, 16'h0001, 16'h0001, 16'h0055);
      tc.slave = ADDR_BCAST;
      cmd_go(tc);
      chk(got === 1'b0 && xv === 1'b1, "broadcast write");
      tc.func = FC_RD_HOLD;
      cmd_go(tc);
      chk(got === 1'b0 && xv === 1'b0, "broadcast read");
      tc.slave = 8'h02;
      cmd_go(tc);
      chk(got === 1'b0 && xv === 1'b0, "foreign address");
      $display("address test done");
      // Datagram exchange, with the transmit side busy once
      dg_rx_avail <= 1'b1;
      cmd_go(mk(FC_DG_RECV, 16'h0000, 16'h0000, 16'h0000));
      ans(EX_NONE, 1'b0, 16'h0000);
      chk(rxq === 1'b1, "datagram fetch");
      dg_tx_busy <= 1'b1;
      cmd_go(mk(FC_DG_SEND, 16'h0000, 16'h0000, 16'h0000));
      ans(EX_DEV_FAIL, 1'b0, 16'h0000);
      chk(txq === 1'b0, "send while busy");
      dg_tx_busy <= 1'b0;
      cmd_go(mk(FC_DG_SEND, 16'h0000, 16'h0000, 16'h0000));
      chk(got === 1'b1 && txq === 1'b1, "datagram send");
      $display("datagram test done");
      // Reference map; configured references are word-type 8010, bit-type 0020 and unmapped FFFF
      wr(R_SEL, 32'h3);
      wr(R_REF, 32'h8010);
      wr(R_CFG, 32'h4);
      wr(R_SEL, 32'h4);
      wr(R_REF, 32'h0020);
      wr(R_SEL, 32'h5);
      wr(R_REF, 32'hFFFF);
      lk(5'h03, 10'h005, '{1'b1, 1'b1, 1'b0, 15'h0015});
      lk(5'h03, 10'h002, '{1'b1, 1'b1, 1'b1, 15'h0012});
      lk(5'h04, 10'h001, '{1'b1, 1'b0, 1'b0, 15'h0021});
      lk(5'h05, 10'h000, '{1'b0, 1'b0, 1'b0, 15'h0000});
      lk(5'h06, 10'h000, '{1'b0, 1'b0, 1'b0, 15'h0000});
      $display("map test done");
      // Mid-run reset brings the changed delimiter back and still answers
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk(delim === DELIM_RST && listen_only === 1'b0, "state after reset");
      cmd_go(mk(FC_DIAG, SF_ECHO, 16'h0000, 16'h1234));
      ans(EX_NONE, 1'b1, 16'h1234);
      $display("second reset test done");
      close_out();
   end
endmodule : fgc_decoder_test
`default_nettype wire
